// >>> hw/deep_sleep_gate_ctrl.sv
// deep-sleep clock gating register with apb slave, fault check and interrupt
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module deep_sleep_gate_ctrl (
    input  logic                                core_clk,
    input  logic                                rst_b,
    input  clk_gate_pkg::apb_req_s              apb_req,
    output clk_gate_pkg::apb_rsp_s              apb_rsp,
    input  clk_gate_pkg::gate_src_s             gate_src,
    input  clk_gate_pkg::periph_req_s           periph_req,
    output logic                                periph_fault,
    output logic [clk_gate_pkg::UNIT_N-1:0]     unit_clk_en,
    output logic                                irq
);
    typedef struct packed {
        logic [31:0]                      deep_gate;
        logic [clk_gate_pkg::UNIT_N-1:0]  unit_en;
        logic [clk_gate_pkg::EVT_N-1:0]   irq_status;
        logic [clk_gate_pkg::EVT_N-1:0]   irq_enable;
        logic [31:0]                      rdata;
        logic                             slverr;
        logic                             in_deep;
    } dsg_state_s;

    localparam dsg_state_s ST_RESET = '{
        deep_gate:  clk_gate_pkg::GATE_RESET,
        unit_en:    '0,
        irq_status: clk_gate_pkg::IRQ_RESET,
        irq_enable: clk_gate_pkg::IRQ_RESET,
        rdata:      '0,
        slverr:     1'b0,
        in_deep:    1'b0};

    dsg_state_s st_q;
    dsg_state_s st_d;

    logic                             setup_ph;
    logic                             access_ph;
    logic                             hit_gate;
    logic                             hit_status;
    logic                             hit_clear;
    logic                             hit_enable;
    logic                             hit_any;
    logic [31:0]                      lane_mask;
    logic [clk_gate_pkg::UNIT_N-1:0]  unit_sel_en;
    logic                             unit_known;
    logic [clk_gate_pkg::EVT_N-1:0]   evt_set;
    logic [clk_gate_pkg::EVT_N-1:0]   evt_clr;
    logic                             deep_now;
    logic                             wr_ok;

    assign setup_ph   = apb_req.psel & ~apb_req.penable;
    assign access_ph  = apb_req.psel & apb_req.penable;
    assign hit_gate   = apb_req.paddr == clk_gate_pkg::DEEP_GATE_1_OFF;
    assign hit_status = apb_req.paddr == clk_gate_pkg::IRQ_STATUS_OFF;
    assign hit_clear  = apb_req.paddr == clk_gate_pkg::IRQ_CLEAR_OFF;
    assign hit_enable = apb_req.paddr == clk_gate_pkg::IRQ_ENABLE_OFF;
    assign hit_any    = hit_gate | hit_status | hit_clear | hit_enable;
    assign wr_ok      = access_ph & apb_req.pwrite & ~st_q.slverr;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign lane_mask[8*b +: 8] = {8{apb_req.pstrb[b]}};
    end

    gate_mode_mux u_mux (
        .src       (gate_src),
        .deep_gate (st_q.deep_gate),
        .unit_en   (unit_sel_en)
    );

    // an index past the last unit has nothing behind it, so it faults too
    assign unit_known   = periph_req.unit < clk_gate_pkg::UNIT_CNT;
    assign periph_fault = periph_req.valid &
                          (~unit_known | ~st_q.unit_en[periph_req.unit]);

    assign deep_now = gate_src.auto_clock_gating_select &
                      (gate_src.mode == clk_gate_pkg::PWR_DEEP);

    always_comb begin
        st_d = st_q;

        // enables are registered so faults and clocks always agree
        st_d.unit_en = unit_sel_en;
        st_d.in_deep = deep_now;

        // setup phase: decode and fetch read data ahead of the access phase
        if (setup_ph) begin
            st_d.slverr = ~hit_any;
            st_d.rdata  = '0;
            if (hit_gate) begin
                st_d.rdata = st_q.deep_gate & clk_gate_pkg::GATE_IMPL_MASK;
            end
            if (hit_status) begin
                st_d.rdata[clk_gate_pkg::EVT_N-1:0] = st_q.irq_status;
            end
            if (hit_enable) begin
                st_d.rdata[clk_gate_pkg::EVT_N-1:0] = st_q.irq_enable;
            end
        end

        if (wr_ok && hit_gate) begin
            // reserved positions keep zero whatever is written
            st_d.deep_gate = (st_q.deep_gate & ~(lane_mask & clk_gate_pkg::GATE_IMPL_MASK)) |
                             (apb_req.pwdata & lane_mask & clk_gate_pkg::GATE_IMPL_MASK);
        end
        if (wr_ok && hit_enable && apb_req.pstrb[0]) begin
            st_d.irq_enable = apb_req.pwdata[clk_gate_pkg::EVT_N-1:0];
        end

        evt_clr = '0;
        if (wr_ok && hit_clear && apb_req.pstrb[0]) begin
            evt_clr = apb_req.pwdata[clk_gate_pkg::EVT_N-1:0];
        end
        evt_set = '0;
        evt_set[clk_gate_pkg::EVT_GATE_FAULT] = periph_fault;
        evt_set[clk_gate_pkg::EVT_DEEP_ENTRY] = deep_now & ~st_q.in_deep;
        evt_set[clk_gate_pkg::EVT_DEEP_EXIT]  = ~deep_now & st_q.in_deep;
        // a new event in the clearing cycle survives the clear
        st_d.irq_status = (st_q.irq_status & ~evt_clr) | evt_set;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign apb_rsp.pready  = access_ph;
    assign apb_rsp.prdata  = st_q.rdata;
    assign apb_rsp.pslverr = access_ph & st_q.slverr;
    assign unit_clk_en     = st_q.unit_en;
    assign irq             = |(st_q.irq_status & st_q.irq_enable);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [clk_gate_pkg::UNIT_N-1:0] deep_units;
    logic [clk_gate_pkg::UNIT_N-1:0] run_units;
    logic [clk_gate_pkg::UNIT_N-1:0] sleep_units;
    logic                            gate_wr;
    logic                            enable_wr;
    logic                            clear_wr;

    assign gate_wr   = access_ph & apb_req.pwrite & hit_gate;
    assign enable_wr = access_ph & apb_req.pwrite & hit_enable;
    assign clear_wr  = access_ph & apb_req.pwrite & hit_clear & apb_req.pstrb[0];

    for (genvar u = 0; u < clk_gate_pkg::UNIT_N; u++) begin : g_chk_map
        assign deep_units[u] = st_q.deep_gate[clk_gate_pkg::UNIT_BIT[u]];
        assign run_units[u]  = gate_src.run_gate[clk_gate_pkg::UNIT_BIT[u]];
        assign sleep_units[u] = gate_src.sleep_gate[clk_gate_pkg::UNIT_BIT[u]];
    end

    sequence s_full_gate_write;
        access_ph && apb_req.pwrite && hit_gate && (apb_req.pstrb == 4'hF);
    endsequence

    sequence s_gate_read_setup;
        setup_ph && !apb_req.pwrite && hit_gate;
    endsequence

    sequence s_deep_held;
        deep_now [*3];
    endsequence

    sequence s_unmapped_setup;
        setup_ph && !hit_any;
    endsequence

    sequence s_enable_read_setup;
        setup_ph && !apb_req.pwrite && hit_enable;
    endsequence

    sequence s_clear_read_setup;
        setup_ph && !apb_req.pwrite && hit_clear;
    endsequence

    sequence s_deep_enter;
        !deep_now ##1 deep_now;
    endsequence

    sequence s_deep_leave;
        deep_now ##1 !deep_now;
    endsequence

    chk_reset_clear: assert property (
        @(posedge core_clk) $rose(rst_b) |-> (st_q.deep_gate == clk_gate_pkg::GATE_RESET)
                                          && (unit_clk_en == '0))
        else $error("gating word not zero after reset");

    chk_reserved_zero: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (st_q.deep_gate & ~clk_gate_pkg::GATE_IMPL_MASK) == '0)
        else $error("reserved gating bit became set");

    chk_gate_write: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_full_gate_write |=> (st_q.deep_gate ==
                               ($past(apb_req.pwdata) & clk_gate_pkg::GATE_IMPL_MASK)))
        else $error("gating write not stored as masked data");

    chk_write_no_err: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        access_ph && hit_gate |-> !apb_rsp.pslverr && apb_rsp.pready)
        else $error("gating word access answered with error");

    chk_gate_read: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_gate_read_setup ##1 access_ph |-> (apb_rsp.prdata ==
                               ($past(st_q.deep_gate) & clk_gate_pkg::GATE_IMPL_MASK)))
        else $error("gating word read back wrong");

    chk_fault_gated: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        periph_req.valid && unit_known && !unit_clk_en[periph_req.unit] |-> periph_fault)
        else $error("access to unclocked unit not faulted");

    chk_clocked_ok: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        periph_req.valid && unit_known && unit_clk_en[periph_req.unit] |-> !periph_fault)
        else $error("access to clocked unit faulted");

    chk_deep_select: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_deep_held |=> (unit_clk_en == $past(deep_units)))
        else $error("deep-sleep word not applied in deep-sleep");

    chk_no_auto_run: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !gate_src.auto_clock_gating_select |=> (unit_clk_en == $past(run_units)))
        else $error("run word not applied without auto gating");

    chk_comparator_map: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        deep_now && st_q.deep_gate[clk_gate_pkg::COMPARATOR_A_GATE_BIT]
        |=> unit_clk_en[9])
        else $error("comparator gate bit not driving its unit");

    chk_counter_map: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        deep_now |=> (unit_clk_en[8:6] == $past(st_q.deep_gate[18:16])))
        else $error("counter gate bits misrouted");

    chk_two_wire_map: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        deep_now |=> (unit_clk_en[5] == $past(st_q.deep_gate[12])))
        else $error("two-wire gate bit misrouted");

    chk_serial_map: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        deep_now |=> (unit_clk_en[4:0] == {$past(st_q.deep_gate[5:4]), $past(st_q.deep_gate[2:0])}))
        else $error("serial gate bits misrouted");

    chk_fault_sticky: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        periph_fault |=> st_q.irq_status[clk_gate_pkg::EVT_GATE_FAULT])
        else $error("fault event not latched");

    chk_irq_level: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        periph_fault && st_q.irq_enable[clk_gate_pkg::EVT_GATE_FAULT] && !enable_wr |=> irq)
        else $error("enabled fault did not raise interrupt");

    chk_unmapped_err: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_unmapped_setup ##1 access_ph |-> apb_rsp.pslverr)
        else $error("unmapped offset not answered with error");

    chk_unmapped_zero: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_unmapped_setup ##1 (access_ph && !apb_req.pwrite) |-> (apb_rsp.prdata == '0))
        else $error("unmapped read returned data");

    chk_gate_hold: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !gate_wr |=> $stable(st_q.deep_gate))
        else $error("gating word changed without a write");

    chk_lane_keep: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        gate_wr && !apb_req.pstrb[0] |=> (st_q.deep_gate[7:0] == $past(st_q.deep_gate[7:0])))
        else $error("unstrobed gating lane changed");

    chk_lane_write: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        gate_wr && apb_req.pstrb[0]
        |=> (st_q.deep_gate[7:0] == ($past(apb_req.pwdata[7:0]) & clk_gate_pkg::GATE_IMPL_MASK[7:0])))
        else $error("strobed gating lane not written");

    chk_enable_write: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        enable_wr && apb_req.pstrb[0]
        |=> (st_q.irq_enable == $past(apb_req.pwdata[clk_gate_pkg::EVT_N-1:0])))
        else $error("interrupt enable not written");

    chk_enable_hold: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !enable_wr |=> $stable(st_q.irq_enable))
        else $error("interrupt enable changed without a write");

    chk_clear_bits: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        clear_wr |=> ((st_q.irq_status & ~$past(evt_set)
                       & $past(apb_req.pwdata[clk_gate_pkg::EVT_N-1:0])) == '0))
        else $error("status bit survived its clear");

    chk_status_sticky: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        1'b1 |=> ((($past(st_q.irq_status) & ~$past(evt_clr)) & ~st_q.irq_status) == '0))
        else $error("status bit lost without a clear");

    chk_no_spurious: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        1'b1 |=> ((st_q.irq_status & ~$past(st_q.irq_status) & ~$past(evt_set)) == '0))
        else $error("status bit set without an event");

    chk_entry_event: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_deep_enter |=> st_q.irq_status[clk_gate_pkg::EVT_DEEP_ENTRY])
        else $error("deep-sleep entry not recorded");

    chk_exit_event: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_deep_leave |=> st_q.irq_status[clk_gate_pkg::EVT_DEEP_EXIT])
        else $error("deep-sleep exit not recorded");

    chk_fault_needs_valid: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !periph_req.valid |-> !periph_fault)
        else $error("fault raised with no access");

    chk_unknown_unit: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        periph_req.valid && !unit_known |-> periph_fault)
        else $error("access to missing unit not faulted");

    chk_sleep_select: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        gate_src.auto_clock_gating_select && (gate_src.mode == clk_gate_pkg::PWR_SLEEP)
        |=> (unit_clk_en == $past(sleep_units)))
        else $error("sleep word not applied in sleep");

    chk_run_auto: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        gate_src.auto_clock_gating_select && (gate_src.mode == clk_gate_pkg::PWR_RUN)
        |=> (unit_clk_en == $past(run_units)))
        else $error("run word not applied in run mode");

    chk_rdata_hold: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !setup_ph |=> $stable(apb_rsp.prdata))
        else $error("read data moved outside a setup");

    chk_enable_read: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_enable_read_setup ##1 access_ph |-> (apb_rsp.prdata == 32'($past(st_q.irq_enable))))
        else $error("interrupt enable read back wrong");

    chk_clear_read_zero: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_clear_read_setup ##1 access_ph |-> (apb_rsp.prdata == '0))
        else $error("clear register returned data");
endmodule : deep_sleep_gate_ctrl

// >>> hw/clk_gate_pkg.sv
// constants, types and register map for the deep-sleep clock gating register
package clk_gate_pkg;
    localparam int              DATA_W          = 32;
    localparam int              ADDR_W          = 12;
    localparam logic [31:0]     SYS_CTRL_BASE   = 32'h400F_E000;
    localparam logic [11:0]     DEEP_GATE_1_OFF = 12'h124;
    localparam logic [11:0]     IRQ_STATUS_OFF  = 12'h200;
    localparam logic [11:0]     IRQ_CLEAR_OFF   = 12'h204;
    localparam logic [11:0]     IRQ_ENABLE_OFF  = 12'h208;
    localparam logic [31:0]     GATE_RESET      = 32'h0000_0000;
    localparam logic [31:0]     GATE_IMPL_MASK  = 32'h0107_1037;

    localparam int ASYNC_SERIAL_A_GATE_BIT = 0;
    localparam int ASYNC_SERIAL_B_GATE_BIT = 1;
    localparam int ASYNC_SERIAL_C_GATE_BIT = 2;
    localparam int SYNC_SERIAL_A_GATE_BIT  = 4;
    localparam int SYNC_SERIAL_B_GATE_BIT  = 5;
    localparam int TWO_WIRE_A_GATE_BIT     = 12;
    localparam int GP_COUNTER_A_GATE_BIT   = 16;
    localparam int GP_COUNTER_B_GATE_BIT   = 17;
    localparam int GP_COUNTER_C_GATE_BIT   = 18;
    localparam int COMPARATOR_A_GATE_BIT   = 24;

    localparam int                  UNIT_N     = 10;
    localparam int                  UNIT_IDX_W = 4;
    localparam logic [UNIT_IDX_W-1:0] UNIT_CNT = 4'hA;
    // unit index -> gating bit position
    localparam int UNIT_BIT [UNIT_N] = '{
        ASYNC_SERIAL_A_GATE_BIT, ASYNC_SERIAL_B_GATE_BIT, ASYNC_SERIAL_C_GATE_BIT,
        SYNC_SERIAL_A_GATE_BIT, SYNC_SERIAL_B_GATE_BIT, TWO_WIRE_A_GATE_BIT,
        GP_COUNTER_A_GATE_BIT, GP_COUNTER_B_GATE_BIT, GP_COUNTER_C_GATE_BIT,
        COMPARATOR_A_GATE_BIT};

    localparam int          EVT_N          = 3;
    localparam int          EVT_GATE_FAULT = 0;
    localparam int          EVT_DEEP_ENTRY = 1;
    localparam int          EVT_DEEP_EXIT  = 2;
    localparam logic [2:0]  IRQ_RESET      = 3'h0;

    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} pwr_mode_e;

    typedef struct packed {
        logic [31:0] run_gate;
        logic [31:0] sleep_gate;
        logic        auto_clock_gating_select;
        pwr_mode_e   mode;
    } gate_src_s;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [UNIT_IDX_W-1:0] unit;
    } periph_req_s;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } apb_req_s;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } apb_rsp_s;
endpackage : clk_gate_pkg

// >>> hw/gate_mode_mux.sv
// picks the gating word for the current power mode and spreads it onto units
`timescale 1ns/1ns
module gate_mode_mux (
    input  clk_gate_pkg::gate_src_s                 src,
    input  logic [31:0]                             deep_gate,
    output logic [clk_gate_pkg::UNIT_N-1:0]         unit_en
);
    logic [31:0] chosen;

    always_comb begin
        chosen = src.run_gate;
        // without auto gating the run word holds in every mode
        if (src.auto_clock_gating_select) begin
            case (src.mode)
                clk_gate_pkg::PWR_SLEEP: chosen = src.sleep_gate;
                clk_gate_pkg::PWR_DEEP:  chosen = deep_gate;
                default:                 chosen = src.run_gate;
            endcase
        end
    end

    for (genvar i = 0; i < clk_gate_pkg::UNIT_N; i++) begin : g_unit
        assign unit_en[i] = chosen[clk_gate_pkg::UNIT_BIT[i]];
    end
endmodule : gate_mode_mux

// >>> tb/periph_access_model.sv
// bus access source standing for the gated peripherals behind the gating block
`timescale 1ns/1ns
module periph_access_model (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic                 go,
    input  wire logic [3:0]           unit,
    output clk_gate_pkg::periph_req_s periph_req
);
    // one access cycle per request; when idle the index and direction keep changing
    // so that a stale index can never pass for a live access
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            periph_req <= '0;
        end else begin
            periph_req.valid <= go;
            periph_req.write <= ~periph_req.write;
            periph_req.unit  <= go ? unit : ~periph_req.unit;
        end
    end
endmodule : periph_access_model

// >>> tb/deep_sleep_gate_ctrl_test.sv
// self-checking bench for the deep-sleep clock gating register block
`timescale 1ns/1ns
module deep_sleep_gate_ctrl_test;
    logic                      core_clk   = 1'b0;
    logic                      rst_b      = 1'b0;
    clk_gate_pkg::apb_req_s    apb_req    = '0;
    clk_gate_pkg::apb_rsp_s    apb_rsp;
    clk_gate_pkg::gate_src_s   gate_src   = '0;
    clk_gate_pkg::periph_req_s periph_req;
    logic                      periph_fault;
    logic [9:0]                unit_clk_en;
    logic                      irq;
    logic                      acc_go     = 1'b0;
    logic [3:0]                acc_unit   = 4'h0;
    logic [3:0]                wr_strb    = 4'hF;
    logic [31:0]               last_rd;
    int                        fail_count = 0;
    int                        num_checks = 0;
    int                        cyc        = 0;
    int                        ubit [10]  = '{0, 1, 2, 4, 5, 12, 16, 17, 18, 24};

    deep_sleep_gate_ctrl i_deep_sleep_gate_ctrl (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .apb_req      (apb_req),
        .apb_rsp      (apb_rsp),
        .gate_src     (gate_src),
        .periph_req   (periph_req),
        .periph_fault (periph_fault),
        .unit_clk_en  (unit_clk_en),
        .irq          (irq)
    );

    periph_access_model i_periph_access_model (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .go         (acc_go),
        .unit       (acc_unit),
        .periph_req (periph_req)
    );

    always #2 core_clk = ~core_clk;

    // the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one apb transfer; an idle cycle always precedes the setup so no signal is driven twice
    task automatic apb(input logic wr_en, input logic [11:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        @(posedge core_clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr_en;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wdata;
        apb_req.pstrb   <= wr_en ? wr_strb : 4'h0;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        // no wait limit here: only the bench timeout may end a hung transfer
        do begin
            @(posedge core_clk);
        end while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, d, r, x);
        check("write error", {31'h0, e}, {31'h0, x});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
        logic x;
        apb(1'b0, a, 32'h0000_0000, last_rd, x);
        check("read data", exp, last_rd);
        check("read error", {31'h0, e}, {31'h0, x});
    endtask : rd

    // one cycle for the source inputs, one for the registered enables
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic units(input logic [9:0] exp);
        check("clock enables", {22'h0, exp}, {22'h0, unit_clk_en});
    endtask : units

    task automatic touch(input logic [3:0] u, input logic exp);
        @(posedge core_clk);
        acc_go   <= 1'b1;
        acc_unit <= u;
        @(posedge core_clk);
        acc_go   <= 1'b0;
        #1;
        check("bus fault", {31'h0, exp}, {31'h0, periph_fault});
    endtask : touch

    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        units(10'h000);
        check("interrupt", 32'h0, {31'h0, irq});
        rd(12'h124, 32'h0000_0000, 1'b0);
        wr(12'h124, 32'hFFFF_FFFF, 1'b0);
        rd(12'h124, 32'h0107_1037, 1'b0);
        wr(12'h124, last_rd & ~32'h0000_0004, 1'b0);
        rd(12'h124, 32'h0107_1033, 1'b0);
        settle();
        units(10'h000);
        @(posedge core_clk);
        gate_src.auto_clock_gating_select <= 1'b1;
        gate_src.mode                     <= clk_gate_pkg::PWR_DEEP;
        settle();
        units(10'h3FB);
        for (int i = 0; i < 10; i++) begin
            wr(12'h124, 32'h0000_0001 << ubit[i], 1'b0);
            settle();
            units(10'h001 << i);
            touch(4'(i), 1'b0);
            touch(4'((i + 1) % 10), 1'b1);
        end
        touch(4'hA, 1'b1);
        @(posedge core_clk);
        gate_src.sleep_gate <= 32'h0000_0010;
        gate_src.mode       <= clk_gate_pkg::PWR_SLEEP;
        settle();
        units(10'h008);
        @(posedge core_clk);
        gate_src.mode     <= clk_gate_pkg::PWR_RUN;
        gate_src.run_gate <= 32'h0000_0002;
        settle();
        units(10'h002);
        @(posedge core_clk);
        gate_src.auto_clock_gating_select <= 1'b0;
        gate_src.mode                     <= clk_gate_pkg::PWR_DEEP;
        settle();
        units(10'h002);
        // faults, deep-sleep entry and exit all recorded, but nothing enabled yet
        rd(12'h200, 32'h0000_0007, 1'b0);
        check("interrupt", 32'h0, {31'h0, irq});
        wr(12'h208, 32'h0000_0001, 1'b0);
        rd(12'h208, 32'h0000_0001, 1'b0);
        settle();
        check("interrupt", 32'h1, {31'h0, irq});
        wr(12'h204, 32'h0000_0001, 1'b0);
        settle();
        check("interrupt", 32'h0, {31'h0, irq});
        wr(12'h200, 32'h0000_0007, 1'b0);
        rd(12'h200, 32'h0000_0006, 1'b0);
        wr(12'h204, 32'h0000_0006, 1'b0);
        rd(12'h200, 32'h0000_0000, 1'b0);
        rd(12'h204, 32'h0000_0000, 1'b0);
        rd(12'h100, 32'h0000_0000, 1'b1);
        wr(12'h100, 32'hFFFF_FFFF, 1'b1);
        rd(12'h124, 32'h0100_0000, 1'b0);
        wr_strb = 4'h1;
        wr(12'h124, 32'hFFFF_FFFF, 1'b0);
        rd(12'h124, 32'h0100_0037, 1'b0);
        wr_strb = 4'hE;
        wr(12'h124, 32'h0000_0000, 1'b0);
        rd(12'h124, 32'h0000_0037, 1'b0);
        print_verdict();
    end
endmodule : deep_sleep_gate_ctrl_test
